// File: core/bcc_pkg.sv
package bcc_pkg;

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    localparam logic [6:0] I2C_DEV_ADDR = 7'h5B;
    localparam logic [3:0] ACK_SLOT = 4'h8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_VOLT = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h11;
    localparam logic [7:0] OFF_RSVD = 8'h12;
    localparam logic [7:0] OFF_EN = 8'h13;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int VCODE_MSB = 5;
    localparam int RANGE_BIT = 6;
    localparam int MODE_BIT = 0;
    localparam int EN_BIT = 0;
    localparam int PG_BIT = 1;
    localparam int WEXACT_BIT = 2;

    // ----------------------------------------------------------------
    // Default register contents, per part
    // ----------------------------------------------------------------
    localparam logic [7:0] DEF_VOLT = 8'h40;
    localparam logic [7:0] DEF_MODE = 8'h00;
    localparam logic [7:0] DEF_RSVD = 8'h00;
    localparam logic [7:0] DEF_EN = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_MACK, ST_DONE
    } bcc_state_t;

    typedef struct packed {
        logic rangeSelect;
        logic [5:0] voltageCode;
        logic forcedPwm;
        logic channelEnable;
        logic writeExact;
    } bcc_ctrl_t;

    // Low range: upper bits 00 and codes 010000/010001 have no target
    function automatic logic code_avail(input logic rangeSel, input logic [5:0] code);
        code_avail = rangeSel || ((code[5:4] != 2'h0) && (code[5:1] != 5'h08));
    endfunction

endpackage

// File: core/bcc_regs.sv
`timescale 1ns/1ps
// How it works
// - Four byte registers 10h..13h hold range, code, mode, write-exact, power-good, enable.
// - Six-bit voltage code at 10h bits 5..0 is read/write and sets the target.
// - Low range codes 00xxxx, 010000, 010001 unavailable; software avoids them.
// - Mode bit forces PWM, enable bit turns channel on, bit 1 reports power good.
// - Read-only bits ignore writes; all but power good return per-part values.
// - Registers reached only as serial slave at address 1011011, single-byte transfers.
module bcc_regs import bcc_pkg::*; #(
    parameter logic [7:0] RESET_VOLT = DEF_VOLT,
    parameter logic [7:0] RESET_MODE = DEF_MODE,
    parameter logic [7:0] RESET_RSVD = DEF_RSVD,
    parameter logic [7:0] RESET_EN = DEF_EN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial port pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Converter side
    input wire logic powerGood,
    output bcc_ctrl_t ctrl,
    output logic codeAvailable
);

    // ----------------------------------------------------------------
    // Line sampling and bus conditions
    // ----------------------------------------------------------------
    logic sclQ;
    logic sdaQ;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end else begin
            sclQ <= sclIn;
            sdaQ <= sdaIn;
        end
    end

    assign sclRise = sclIn & ~sclQ;
    assign sclFall = ~sclIn & sclQ;
    assign startCond = sclIn & sclQ & sdaQ & ~sdaIn;
    assign stopCond = sclIn & sclQ & ~sdaQ & sdaIn;

    // ----------------------------------------------------------------
    // Transfer state
    // ----------------------------------------------------------------
    bcc_state_t stQ;
    logic [3:0] bitCntQ;
    logic ackSlotQ;
    logic sdaOeQ;
    logic [7:0] shiftQ;
    logic [7:0] ptrQ;
    logic [7:0] txQ;
    logic rwQ;
    bcc_ctrl_t ctrlQ;
    bcc_ctrl_t rstCtrl;
    logic receiving;
    logic ackStart;
    logic ackEnd;
    logic addrHit;
    logic wrStrobe;
    logic [7:0] rdMux;

    assign receiving = (stQ == ST_ADDR) || (stQ == ST_PTR) || (stQ == ST_WDATA);
    assign ackStart = sclFall & receiving & (bitCntQ == ACK_SLOT) & ~ackSlotQ;
    assign ackEnd = sclFall & receiving & ackSlotQ;
    assign addrHit = (shiftQ[7:1] == I2C_DEV_ADDR);
    assign wrStrobe = ackStart & (stQ == ST_WDATA);

    // Read-only bits other than power good (13h bit 1) come straight from the part defaults
    assign rdMux = (ptrQ == OFF_VOLT) ?
                       {RESET_VOLT[7], ctrlQ.rangeSelect, ctrlQ.voltageCode} :
                   (ptrQ == OFF_MODE) ? {RESET_MODE[7:1], ctrlQ.forcedPwm} :
                   (ptrQ == OFF_RSVD) ? RESET_RSVD :
                   (ptrQ == OFF_EN) ?
                       {RESET_EN[7:3], ctrlQ.writeExact, powerGood, ctrlQ.channelEnable} :
                   8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            stQ <= ST_IDLE;
            bitCntQ <= 4'h0;
            ackSlotQ <= 1'b0;
            sdaOeQ <= 1'b0;
            shiftQ <= 8'h00;
            ptrQ <= 8'h00;
            txQ <= 8'h00;
            rwQ <= 1'b0;
        end else if (startCond) begin
            stQ <= ST_ADDR;
            bitCntQ <= 4'h0;
            ackSlotQ <= 1'b0;
            sdaOeQ <= 1'b0;
        end else if (stopCond) begin
            stQ <= ST_IDLE;
            bitCntQ <= 4'h0;
            ackSlotQ <= 1'b0;
            sdaOeQ <= 1'b0;
        end else if (receiving) begin
            if (sclRise && bitCntQ != ACK_SLOT) begin
                shiftQ <= {shiftQ[6:0], sdaIn};
                bitCntQ <= 4'(bitCntQ + 4'h1);
            end else if (ackStart) begin
                ackSlotQ <= 1'b1;
                unique case (stQ)
                    ST_ADDR: begin
                        // Foreign address: stay silent until the next start
                        if (addrHit) begin
                            sdaOeQ <= 1'b1;
                            rwQ <= shiftQ[0];
                        end else begin
                            stQ <= ST_IDLE;
                            ackSlotQ <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        sdaOeQ <= 1'b1;
                        ptrQ <= shiftQ;
                    end
                    ST_WDATA: begin
                        sdaOeQ <= 1'b1;
                    end
                endcase
            end else if (ackEnd) begin
                ackSlotQ <= 1'b0;
                bitCntQ <= 4'h0;
                unique case (stQ)
                    ST_ADDR: begin
                        if (rwQ) begin
                            stQ <= ST_RDATA;
                            txQ <= rdMux;
                            sdaOeQ <= ~rdMux[7];
                        end else begin
                            stQ <= ST_PTR;
                            sdaOeQ <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        stQ <= ST_WDATA;
                        sdaOeQ <= 1'b0;
                    end
                    ST_WDATA: begin
                        // Single-byte writes only; later bytes go unanswered
                        stQ <= ST_DONE;
                        sdaOeQ <= 1'b0;
                    end
                endcase
            end
        end else if (stQ == ST_RDATA) begin
            if (sclRise) begin
                bitCntQ <= 4'(bitCntQ + 4'h1);
            end else if (sclFall) begin
                if (bitCntQ == ACK_SLOT) begin
                    sdaOeQ <= 1'b0;
                    stQ <= ST_MACK;
                    bitCntQ <= 4'h0;
                end else begin
                    txQ <= {txQ[6:0], 1'b0};
                    sdaOeQ <= ~txQ[6];
                end
            end
        end else if (stQ == ST_MACK && sclRise) begin
            stQ <= ST_DONE;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    assign rstCtrl = {RESET_VOLT[RANGE_BIT], RESET_VOLT[VCODE_MSB:0], RESET_MODE[MODE_BIT],
                      RESET_EN[EN_BIT], RESET_EN[WEXACT_BIT]};

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlQ <= rstCtrl;
        end else if (wrStrobe) begin
            case (ptrQ)
                OFF_VOLT: begin
                    ctrlQ.rangeSelect <= shiftQ[RANGE_BIT];
                    ctrlQ.voltageCode <= shiftQ[VCODE_MSB:0];
                end
                OFF_MODE: ctrlQ.forcedPwm <= shiftQ[MODE_BIT];
                OFF_EN: begin
                    ctrlQ.channelEnable <= shiftQ[EN_BIT];
                    ctrlQ.writeExact <= shiftQ[WEXACT_BIT];
                end
                default: ;
            endcase
        end
    end

    assign ctrl = ctrlQ;
    assign codeAvailable = code_avail(ctrlQ.rangeSelect, ctrlQ.voltageCode);
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOeQ;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    addr_ack_a: assert property (ackStart && stQ == ST_ADDR && addrHit |=> sdaOe)
        else $error("own address not acknowledged");
    addr_nack_a: assert property (ackStart && stQ == ST_ADDR && !addrHit |=> !sdaOe [*2])
        else $error("foreign address acknowledged");
    code_write_a: assert property (wrStrobe && ptrQ == OFF_VOLT
            |=> ctrl.voltageCode == $past(shiftQ[VCODE_MSB:0]))
        else $error("voltage code not written");
    range_write_a: assert property (wrStrobe && ptrQ == OFF_VOLT
            |=> ctrl.rangeSelect == $past(shiftQ[RANGE_BIT]))
        else $error("range bit not written");
    enable_write_a: assert property (wrStrobe && ptrQ == OFF_EN
            |=> ctrl.channelEnable == $past(shiftQ[EN_BIT])
            && ctrl.forcedPwm == $past(ctrl.forcedPwm))
        else $error("enable write wrong");
    ro_readback_a: assert property (ackEnd && stQ == ST_ADDR && rwQ && ptrQ == OFF_RSVD
            |=> txQ == RESET_RSVD)
        else $error("read-only register readback wrong");
    map_readback_a: assert property (ackEnd && stQ == ST_ADDR && rwQ && ptrQ == OFF_EN
            |=> txQ[PG_BIT] == $past(powerGood) && txQ[7:3] == RESET_EN[7:3])
        else $error("enable register readback wrong");
    code_avail_a: assert property (!ctrl.rangeSelect && ctrl.voltageCode[5:4] == 2'h0
            |-> !codeAvailable)
        else $error("unavailable code reported usable");
    reset_value_a: assert property (disable iff (1'b0) $past(rst) && !rst
            |-> ctrl == rstCtrl)
        else $error("reset contents wrong");

    write_seen_c: cover property (wrStrobe && ptrQ == OFF_EN);
    read_seen_c: cover property (stQ == ST_RDATA ##[1:300] stQ == ST_MACK);
    foreign_seen_c: cover property (ackStart && stQ == ST_ADDR && !addrHit);

endmodule

// File: dv/bcc_i2c_master.sv
`timescale 1ns/1ps
module bcc_i2c_master (
    // Clock and resolved data line
    input wire logic clk,
    input wire logic sdaWire,
    // Master drive, high means released
    output logic scl,
    output logic sdaDrv
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic step(input logic s, input logic d);
        @(posedge clk);
        scl <= s;
        sdaDrv <= d;
        @(posedge clk);
    endtask
    // Start or repeated start
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    // One byte MSB first, then the ack slot
    task automatic xfer(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
            output logic acked);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, tx[i]);
            step(1'b1, tx[i]);
            rx[i] = sdaWire;
        end
        step(1'b0, ackBit);
        step(1'b1, ackBit);
        acked = !sdaWire;
    endtask
endmodule

// File: dv/buck_channel_control_regs_tb_top.sv
`timescale 1ns/1ps
module buck_channel_control_regs_tb_top;
    import bcc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerGood = 1'b0;
    logic scl, sdaDrv, sdaOut, sdaOe, codeAvailable;
    // Open-drain line with pull-up: device drives its data value only while enabled
    wire sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    bcc_ctrl_t ctrl;
    int mismatches = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'd91548;
    logic [7:0] regs [4];
    logic [7:0] codes [6] = '{8'h0F, 8'h11, 8'h12, 8'h40, 8'h30, 8'hBF};

    bcc_regs bcc_regs_inst (.clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .powerGood(powerGood), .ctrl(ctrl),
        .codeAvailable(codeAvailable));
    bcc_i2c_master bcc_i2c_master_inst (.clk(clk), .sdaWire(sdaWire), .scl(scl),
        .sdaDrv(sdaDrv));

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] expRead(input logic [7:0] p);
        case (p)
            OFF_VOLT: return {DEF_VOLT[7], regs[0][6:0]};
            OFF_MODE: return {DEF_MODE[7:1], regs[1][0]};
            OFF_RSVD: return DEF_RSVD;
            OFF_EN: return {DEF_EN[7:3], regs[3][2], powerGood, regs[3][0]};
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chkCtrl();
        logic av;
        av = regs[0][6] || (regs[0][5:4] != 2'h0 && regs[0][5:1] != 5'h08);
        chk(ctrl, {regs[0][6:0], regs[1][0], regs[3][0], regs[3][2]}, "ctrl");
        chk({9'h000, codeAvailable}, {9'h000, av}, "avail");
    endtask

    // ----------------------------------------------------------------
    // Bus transfers
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] addr, input logic [7:0] p, input logic [7:0] d);
        logic [7:0] rx;
        logic a0, a1, a2;
        bcc_i2c_master_inst.start();
        bcc_i2c_master_inst.xfer(addr, 1'b1, rx, a0);
        bcc_i2c_master_inst.xfer(p, 1'b1, rx, a1);
        bcc_i2c_master_inst.xfer(d, 1'b1, rx, a2);
        bcc_i2c_master_inst.stop();
        chk({7'h00, a0, a1, a2}, (addr == 8'hB6) ? 10'h007 : 10'h000, "acks");
        if (addr == 8'hB6 && p >= OFF_VOLT && p <= OFF_EN) begin
            regs[p[1:0]] = d;
        end
    endtask
    task automatic rd(input logic [7:0] p);
        logic [7:0] rx;
        logic [31:0] r;
        logic a0, a1, a2, a3;
        r = rnd();
        @(posedge clk);
        powerGood <= r[0];
        bcc_i2c_master_inst.start();
        bcc_i2c_master_inst.xfer(8'hB6, 1'b1, rx, a0);
        bcc_i2c_master_inst.xfer(p, 1'b1, rx, a1);
        bcc_i2c_master_inst.start();
        bcc_i2c_master_inst.xfer(8'hB7, 1'b1, rx, a2);
        bcc_i2c_master_inst.xfer(8'hFF, 1'b1, rx, a3);
        bcc_i2c_master_inst.stop();
        chk({6'h00, a0, a1, a2, a3}, 10'h00E, "read acks");
        chk({2'h0, rx}, {2'h0, expRead(p)}, "read data");
    endtask

    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Full run is about 9000 clocks; allow roughly three times that
    initial begin
        #200000;
        mismatches++;
        conclude();
    end

    initial begin
        logic [7:0] p, d;
        logic [31:0] r;
        regs = '{DEF_VOLT, DEF_MODE, DEF_RSVD, DEF_EN};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chkCtrl();
        for (int i = 0; i < 4; i++) begin
            rd(OFF_VOLT + 8'(i));
        end
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            p = (i % 6 == 5) ? 8'h14 : {6'h04, r[9:8]};
            d = r[7:0];
            if (p == OFF_EN) begin
                d[2] = DEF_EN[2];
            end
            wr(8'hB6, p, d);
            chkCtrl();
            rd(p);
        end
        wr(8'hB4, OFF_MODE, ~regs[1]);
        chkCtrl();
        foreach (codes[k]) begin
            wr(8'hB6, OFF_VOLT, codes[k]);
            chkCtrl();
        end
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        regs = '{DEF_VOLT, DEF_MODE, DEF_RSVD, DEF_EN};
        chkCtrl();
        rd(OFF_EN);
        conclude();
    end
endmodule
